/* File: verilog/dio_port.v */
`include "dio_map.vh"
module dio_port #(
  parameter        NUM_LINES   = `DIO_NUM_LINES,
  parameter        HOLD_CYCLES = `DIO_HOLD_CYCLES,
  parameter [0:0]  HV_BUILD    = 1'b0
) (
  input  wire                 clock,
  input  wire                 reset_n,
  // wishbone classic slave
  input  wire                 wb_cyc_i,
  input  wire                 wb_stb_i,
  input  wire                 wb_we_i,
  input  wire [7:0]           wb_adr_i,
  input  wire [3:0]           wb_sel_i,
  input  wire [31:0]          wb_dat_i,
  output reg  [31:0]          wb_dat_o,
  output reg                  wb_ack_o,
  output wire                 wb_err_o,
  // pins: oe low means driving
  input  wire [NUM_LINES-1:0] line_in,
  output wire [NUM_LINES-1:0] line_out,
  output wire [NUM_LINES-1:0] line_oe_n
);
  // ==========================================================================
  // state
  localparam ST_HOLD = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]           state_q;
  reg  [1:0]           state_d;
  reg  [31:0]          hold_cnt_q;
  reg  [NUM_LINES-1:0] dir_q;        // 1 = output
  reg  [NUM_LINES-1:0] level_q;      // driven level for outputs
  reg  [NUM_LINES-1:0] pwr_dir_q;
  reg  [NUM_LINES-1:0] pwr_level_q;
  reg  [NUM_LINES-1:0] cmd_dir_q;    // staged by one command
  reg  [NUM_LINES-1:0] cmd_level_q;
  reg  [NUM_LINES-1:0] snap_q;       // all lines read in one command
  wire [NUM_LINES-1:0] pins_sync;
  wire [NUM_LINES-1:0] readback;
  wire [NUM_LINES-1:0] avail_mask;
  wire [NUM_LINES-1:0] flex_byte;

  wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr       = req & wb_we_i;
  wire hit      = (wb_adr_i == `DIO_OFF_DIR)       | (wb_adr_i == `DIO_OFF_STATE) |
                  (wb_adr_i == `DIO_OFF_PINS)      | (wb_adr_i == `DIO_OFF_PWR_DIR) |
                  (wb_adr_i == `DIO_OFF_PWR_STATE) | (wb_adr_i == `DIO_OFF_CMD) |
                  (wb_adr_i == `DIO_OFF_STATUS);
  wire running  = (state_q == ST_RUN);
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ==========================================================================
  // pins pass two flops before any logic reads them
  dio_sync #(
    .WIDTH    (NUM_LINES)
  ) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (line_in),
    .sync_out (pins_sync)
  );

  // high-voltage build loses the first four flexible lines
  assign avail_mask = HV_BUILD ? ~`DIO_HV_MASK : {NUM_LINES{1'b1}};

  // ==========================================================================
  // per-line output stage, bit n is line n
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi = gi + 1) begin : g_line
      wire usable = avail_mask[gi];
      wire is_out = dir_q[gi];
      wire pin    = pins_sync[gi];
      wire drive  = running & is_out & usable;
      assign line_out[gi]  = drive & level_q[gi];
      assign line_oe_n[gi] = ~drive;
      // usable inputs report the synchronised pin, outputs their driven state; unavailable lines read zero
      assign readback[gi]  = usable & (is_out ? level_q[gi] : pin);
    end
  endgenerate

  // power-up direction read back whole, not only the flexible group in bits 0-7
  assign flex_byte = pwr_dir_q;

  // ==========================================================================
  // power-up sequencing: hold factory inputs, then apply defaults
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (hold_cnt_q >= HOLD_CYCLES - 1) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      state_q    <= ST_HOLD;
      hold_cnt_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (state_q == ST_HOLD) begin
        hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // write decode shared by every register below
  wire                 hit_dir;
  wire                 hit_state;
  wire                 hit_pins;
  wire                 hit_pwr_dir;
  wire                 hit_pwr_state;
  wire                 hit_cmd;
  wire                 hit_status;
  wire                 apply_pwr;
  wire                 live_wr;
  wire                 cmd_go;
  wire [NUM_LINES-1:0] wr_data;
  wire [NUM_LINES-1:0] lane_mask;

  // one strobe per offset, each qualified by a write request
  assign hit_dir       = wr & (wb_adr_i == `DIO_OFF_DIR);
  assign hit_state     = wr & (wb_adr_i == `DIO_OFF_STATE);
  assign hit_pins      = wr & (wb_adr_i == `DIO_OFF_PINS);
  assign hit_pwr_dir   = wr & (wb_adr_i == `DIO_OFF_PWR_DIR);
  assign hit_pwr_state = wr & (wb_adr_i == `DIO_OFF_PWR_STATE);
  assign hit_cmd       = wr & (wb_adr_i == `DIO_OFF_CMD);
  assign hit_status    = wr & (wb_adr_i == `DIO_OFF_STATUS);
  // defaults land on the one edge that leaves the hold
  assign apply_pwr = (state_q == ST_HOLD) & (state_d == ST_RUN);
  // live registers ignore writes during the hold so the lines stay factory inputs
  assign live_wr   = wr & running;
  // the go bit only counts when its byte lane is enabled
  assign cmd_go    = hit_cmd & running & wb_sel_i[0] & wb_dat_i[`DIO_CMD_GO_BIT];
  assign wr_data   = wb_dat_i[NUM_LINES-1:0];
  assign lane_mask = wmask[NUM_LINES-1:0];

  // ==========================================================================
  // live direction, 1 = output; unavailable lines can never become outputs
  always @(posedge clock) begin
    if (!reset_n) begin
      dir_q <= {NUM_LINES{1'b0}};
    end else if (apply_pwr) begin
      dir_q <= pwr_dir_q & avail_mask;
    end else if (hit_dir && live_wr) begin
      dir_q <= ((dir_q & ~lane_mask) | (wr_data & lane_mask)) & avail_mask;
    end else if (cmd_go) begin
      dir_q <= cmd_dir_q & avail_mask;
    end
  end

  // live output levels, only visible on lines set as outputs
  always @(posedge clock) begin
    if (!reset_n) begin
      level_q <= {NUM_LINES{1'b0}};
    end else if (apply_pwr) begin
      level_q <= pwr_level_q;
    end else if (hit_state && live_wr) begin
      level_q <= (level_q & ~lane_mask) | (wr_data & lane_mask);
    end else if (cmd_go) begin
      level_q <= cmd_level_q;
    end
  end

  // ==========================================================================
  // power-up direction, writable at any time; no nonvolatile store behind it
  always @(posedge clock) begin
    if (!reset_n) begin
      pwr_dir_q <= `DIO_RST_PWR_DIR;
    end else if (hit_pwr_dir) begin
      pwr_dir_q <= (pwr_dir_q & ~lane_mask) | (wr_data & lane_mask);
    end
  end

  // power-up levels, applied together with the direction when the hold ends
  always @(posedge clock) begin
    if (!reset_n) begin
      pwr_level_q <= `DIO_RST_PWR_STATE;
    end else if (hit_pwr_state) begin
      pwr_level_q <= (pwr_level_q & ~lane_mask) | (wr_data & lane_mask);
    end
  end

  // ==========================================================================
  // command staging: whole words, so a partial lane write cannot split a command
  always @(posedge clock) begin
    if (!reset_n) begin
      cmd_dir_q <= {NUM_LINES{1'b0}};
    end else if (hit_pins) begin
      cmd_dir_q <= wr_data;
    end
  end

  // staged levels share the status offset, which has no writable field of its own
  always @(posedge clock) begin
    if (!reset_n) begin
      cmd_level_q <= {NUM_LINES{1'b0}};
    end else if (hit_status) begin
      cmd_level_q <= wr_data;
    end
  end

  // every line captured on the same edge that applies the command
  always @(posedge clock) begin
    if (!reset_n) begin
      snap_q <= {NUM_LINES{1'b0}};
    end else if (cmd_go) begin
      snap_q <= readback;
    end
  end

  // ==========================================================================
  // read mux; unmapped offsets read zero rather than erroring
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      `DIO_OFF_DIR: begin
        rd_d[NUM_LINES-1:0] = dir_q;
      end
      `DIO_OFF_STATE: begin
        rd_d[NUM_LINES-1:0] = readback;
      end
      `DIO_OFF_PINS: begin
        rd_d[NUM_LINES-1:0] = cmd_dir_q;
      end
      `DIO_OFF_PWR_DIR: begin
        rd_d[NUM_LINES-1:0] = flex_byte;
      end
      `DIO_OFF_PWR_STATE: begin
        rd_d[NUM_LINES-1:0] = pwr_level_q;
      end
      `DIO_OFF_CMD: begin
        rd_d[NUM_LINES-1:0] = snap_q;
      end
      `DIO_OFF_STATUS: begin
        rd_d[`DIO_STAT_HELD_BIT] = ~running;
        rd_d[`DIO_STAT_HV_BIT]   = HV_BUILD;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // data registered with the ack and cleared otherwise, so it stands for one cycle only
  always @(posedge clock) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_d;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // a miss is acked with zero data rather than an error, hit kept for clarity
  assign wb_err_o = 1'b0 & hit;
endmodule

/* File: pkg/dio_map.vh */
`ifndef DIO_MAP_VH
`define DIO_MAP_VH
// ==========================================================================
// register offsets (byte addresses, one 32-bit word each)
`define DIO_OFF_DIR          8'h00
`define DIO_OFF_STATE        8'h04
`define DIO_OFF_PINS         8'h08
`define DIO_OFF_PWR_DIR      8'h0c
`define DIO_OFF_PWR_STATE    8'h10
`define DIO_OFF_CMD          8'h14
`define DIO_OFF_STATUS       8'h18
// ==========================================================================
// line layout
`define DIO_NUM_LINES        20
`define DIO_FLEX_LO          0
`define DIO_FLEX_HI          7
`define DIO_EXT_LO           8
`define DIO_EXT_HI           15
`define DIO_CTL_LO           16
`define DIO_CTL_HI           19
`define DIO_HV_MASK          20'h0000f
// ==========================================================================
// reset values: factory default is every line an input
`define DIO_RST_PWR_DIR      20'h00000
`define DIO_RST_PWR_STATE    20'h00000
// ==========================================================================
// power-up hold time, 5 ms at 50 MHz
`define DIO_HOLD_NS          5000000
`define DIO_CLK_NS           20
`define DIO_HOLD_CYCLES      (`DIO_HOLD_NS / `DIO_CLK_NS)
// ==========================================================================
// command and status word fields
`define DIO_CMD_GO_BIT       0
`define DIO_STAT_HELD_BIT    0
`define DIO_STAT_HV_BIT      1
`endif

/* File: verilog/dio_sync.v */
`include "dio_map.vh"
// ==========================================================================
// two-stage synchroniser for a bus of pin inputs
module dio_sync #(
  parameter WIDTH = 20
) (
  input  wire             clock,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clock) begin
    if (!reset_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

/* File: tb/dio_port_sva.sv */
module dio_port_sva #(
  parameter       HOLD_CYCLES = 20,
  parameter [0:0] HV_BUILD    = 1'b0
) (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [19:0] line_out,
  input wire logic [19:0] line_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  // ==========================================
  // cycles since reset release, saturating so live writes are only judged well after the hold
  always @(posedge clock) begin
    if (!reset_n) cnt_q <= 0;
    else if (cnt_q < HOLD_CYCLES + 2) cnt_q <= cnt_q + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_dir_wr;
    s_req ##1 wb_we_i && wb_adr_i == 8'h00 && wb_sel_i == 4'hf && cnt_q == HOLD_CYCLES + 2;
  endsequence
  sequence s_lvl_wr;
    s_req ##1 wb_we_i && wb_adr_i == 8'h04 && wb_sel_i == 4'hf && cnt_q == HOLD_CYCLES + 2;
  endsequence
  a_ack_latency: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  a_err_quiet: assert property (!wb_err_o) else $error("bus error raised");
  a_hold_inputs: assert property (cnt_q < HOLD_CYCLES |-> &line_oe_n) else $error("drive in hold");
  a_idle_low: assert property ((line_out & line_oe_n) == 20'h00000) else $error("undriven line high");
  a_hv_inputs: assert property (HV_BUILD |-> line_oe_n[3:0] == 4'hf) else $error("hv line driven");
  a_dir_apply: assert property (s_dir_wr |=> line_oe_n == (~$past(wb_dat_i[19:0])
    | (HV_BUILD ? 20'h0000f : 20'h00000))) else $error("direction not applied");
  a_lvl_apply: assert property (s_lvl_wr |=> line_out == ($past(wb_dat_i[19:0]) & ~line_oe_n))
    else $error("level not applied");
endmodule

/* File: tb/dio_pins_model.sv */
module dio_pins_model (
  input  wire logic [19:0] line_out,
  input  wire logic [19:0] line_oe_n,
  input  wire logic [19:0] ext_en,
  input  wire logic [19:0] ext_val,
  output wire logic [19:0] line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released lines go to the pull-up unless a source drives them; driven lines read back
  assign line_in = (~line_oe_n & line_out) | (line_oe_n & (~ext_en | ext_val));
endmodule

/* File: tb/tb_top.sv */
`include "dio_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  typedef struct {logic [19:0] dir, lvl, en, val;} dio_row_t;
  logic        clock = 1'b0, reset_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, wb_rdat, rd;
  logic [19:0] ext_en = 20'h00000, ext_val = 20'h00000, pins, lout, oen, hv_oen;
  int          n_mismatch = 0, cmp_count = 0, i;
  dio_row_t    rows[4] = '{'{20'h00000, 20'hfffff, 20'hfffff, 20'h0f0f0}, '{20'h00001, 20'h00001, 20'h0, 20'h0},
    '{20'hf0000, 20'h50000, 20'h0ffff, 20'h0a5a5}, '{20'hfffff, 20'ha5a5a, 20'h0, 20'h0}};
  dio_port #(.HOLD_CYCLES(HOLD)) DUT (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .wb_err_o(), .line_in(pins), .line_out(lout), .line_oe_n(oen));
  dio_port #(.HOLD_CYCLES(HOLD), .HV_BUILD(1'b1)) dut_hv (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(),
    .wb_ack_o(), .wb_err_o(), .line_in(20'hfffff), .line_out(), .line_oe_n(hv_oen));
  dio_pins_model u_pins (.line_out(lout), .line_oe_n(oen), .ext_en(ext_en), .ext_val(ext_val), .line_in(pins));
  // ==========================================
  initial forever #10 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one classic cycle; entered just after an edge, leaves the bus idle for a cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (wb_ack !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask
  // ==========================================
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    wb(0, `DIO_OFF_STATUS, 32'h0);
    chk("held", rd, 32'h1);
    wb(1, `DIO_OFF_DIR, 32'hfffff);
    wb(1, `DIO_OFF_PWR_DIR, 32'h000ff);
    wb(1, `DIO_OFF_PWR_STATE, 32'h00055);
    chk("oe_hold", oen, 32'hfffff);
    repeat (HOLD + 4) @(posedge clock);
    chk("oe_pwr", oen, 32'hfff00);
    chk("out_pwr", lout, 32'h00055);
    wb(0, `DIO_OFF_PWR_DIR, 32'h0);
    chk("pwr_dir", rd, 32'h000ff);
    wb(0, 8'h1c, 32'h0);
    chk("unmapped", rd, 32'h0);
    // table rows: direction, level and far-side drive against pins and readback
    for (i = 0; i < 4; i++) begin
      ext_en <= rows[i].en;
      ext_val <= rows[i].val;
      wb(1, `DIO_OFF_STATE, {12'h000, rows[i].lvl});
      wb(1, `DIO_OFF_DIR, {12'h000, rows[i].dir});
      repeat (3) @(posedge clock);
      wb(0, `DIO_OFF_STATE, 32'h0);
      chk("oe", oen, {12'h000, ~rows[i].dir});
      chk("out", lout, {12'h000, rows[i].lvl & rows[i].dir});
      chk("rd", rd, {12'h000, (rows[i].lvl & rows[i].dir) | (~rows[i].dir & (~rows[i].en | rows[i].val))});
    end
    chk("hv", hv_oen, 32'h0000f);
    // whole-port command: staged direction and levels land together
    wb(1, `DIO_OFF_PINS, 32'h0000f);
    wb(1, `DIO_OFF_STATUS, 32'h00005);
    wb(1, `DIO_OFF_CMD, 32'h1);
    repeat (3) @(posedge clock);
    wb(1, `DIO_OFF_CMD, 32'h1);
    chk("cmd_oe", oen, 32'hffff0);
    chk("cmd_out", lout, 32'h00005);
    wb(0, `DIO_OFF_CMD, 32'h0);
    chk("snap", rd, 32'hffff5);
    // reset in mid-run brings back the factory inputs
    reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk("oe_rst", oen, 32'hfffff);
    wb(0, `DIO_OFF_PWR_DIR, 32'h0);
    chk("pwr_dir_rst", rd, 32'h0);
    repeat (HOLD + 4) @(posedge clock);
    chk("oe_factory", oen, 32'hfffff);
    conclude();
  end
endmodule
bind dio_port dio_port_sva #(.HOLD_CYCLES(HOLD_CYCLES), .HV_BUILD(HV_BUILD)) u_sva (.clock(clock),
  .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .line_out(line_out),
  .line_oe_n(line_oe_n));
